// *** verilog/aqdb_pkg.sv ***
// Shared constants and carrier types of the admin queue and doorbell registers.
// Assumes a 32-bit AXI4-Lite register bus with a 16-bit byte address.
package aqdb_pkg;

  // ****************************************
  // Register map (byte addresses)
  // ****************************************
  localparam int          AXI_ADDR_W   = 16;
  localparam logic [15:0] OFS_SIZES    = 16'h0024;
  localparam logic [15:0] OFS_SQ_LO    = 16'h0028;
  localparam logic [15:0] OFS_SQ_HI    = 16'h002c;
  localparam logic [15:0] OFS_CQ_LO    = 16'h0030;
  localparam logic [15:0] OFS_CQ_HI    = 16'h0034;
  localparam logic [15:0] OFS_CONFIG   = 16'h0040;
  localparam logic [15:0] OFS_IRQ_STAT = 16'h0044;
  localparam logic [15:0] OFS_IRQ_MASK = 16'h0048;
  localparam logic [15:0] OFS_DOORBELL = 16'h1000;

  // ****************************************
  // Field layouts and reset values
  // ****************************************
  localparam int          DEPTH_W      = 12;
  localparam int          CQ_DEPTH_LSB = 16;
  localparam int          SQ_DEPTH_LSB = 0;
  localparam int          BASE_LSB     = 12;
  localparam int          BASE_LO_W    = 20;
  localparam int          BASE_W       = 52;
  localparam int          TAIL_W       = 16;
  localparam int          STRIDE_LSB   = 0;
  localparam int          MPS_LSB      = 4;
  localparam int          ARB_LSB      = 8;
  localparam int          SET_W        = 4;
  localparam int          ARB_W        = 3;
  localparam int          DB_SHIFT     = 2;
  localparam logic [15:0] ADMIN_QID    = 16'h0000;
  localparam logic [10:0] ADMIN_VECTOR = 11'h000;

  // ****************************************
  // Interrupt events
  // ****************************************
  localparam int NUM_EVENTS  = 5;
  localparam int EV_ADMIN_DB = 0;
  localparam int EV_IO_DB    = 1;
  localparam int EV_BAD_DB   = 2;
  localparam int EV_MISALIGN = 3;
  localparam int EV_BAD_SIZE = 4;

  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  typedef enum {ST_IDLE, ST_UPDATE} db_state_e;

  typedef struct packed {
    logic [15:0] depth;
    logic [15:0] tail;
  } queue_entry_s;

  typedef struct packed {
    logic        valid;
    logic [15:0] qid;
    logic [15:0] depth;
  } queue_create_s;

  typedef struct packed {
    logic        valid;
    logic [15:0] qid;
    logic [15:0] count;
    logic [15:0] tail;
  } new_cmds_s;

  typedef struct packed {
    logic [15:0]        qid;
    logic [10:0]        cqVector;
    logic [ARB_W-1:0]   arbSel;
    logic [SET_W-1:0]   pageSize;
    logic [DEPTH_W-1:0] sqDepth;
    logic [DEPTH_W-1:0] cqDepth;
    logic [63:0]        sqBase;
    logic [63:0]        cqBase;
  } admin_queues_s;

endpackage

// *** verilog/tail_store.sv ***
// Per-queue tail pointer and depth store with a registered read port.
// Assumes one writer and one reader on the same clock.
`timescale 1ns/1ps
module tail_store #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 16
) (
  input  wire logic                     core_clk,
  input  wire logic                     sys_rst,
  input  wire logic                     wrEn,
  input  wire logic [$clog2(DEPTH)-1:0] wrAddr,
  input  wire logic [WIDTH-1:0]         wrData,
  input  wire logic                     rdEn,
  input  wire logic [$clog2(DEPTH)-1:0] rdAddr,
  output logic      [WIDTH-1:0]         rdData
);

  logic [WIDTH-1:0] mem [DEPTH];

  always_ff @(posedge core_clk) begin
    if (wrEn) begin
      mem[wrAddr] <= wrData;
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      rdData <= '0;
    end else if (rdEn) begin
      rdData <= mem[rdAddr];
    end
  end

endmodule

// *** verilog/admin_queue_doorbell_regs.sv ***
// Admin queue attribute and base registers plus submission tail doorbells.
// Assumes an AXI4-Lite master with one write and one read outstanding and a
// queue-creation source that reports I/O queue depths.
//
// Decided for this implementation: register access over AXI4-Lite.
`timescale 1ns/1ps

module admin_queue_doorbell_regs #(
  parameter int NUM_QUEUES = 16
) (
  input  wire logic                    core_clk,
  input  wire logic                    sys_rst,
  input  wire logic [15:0]             s_axi_awaddr,
  input  wire logic                    s_axi_awvalid,
  output logic                         s_axi_awready,
  input  wire logic [31:0]             s_axi_wdata,
  input  wire logic [3:0]              s_axi_wstrb,
  input  wire logic                    s_axi_wvalid,
  output logic                         s_axi_wready,
  output logic [1:0]                   s_axi_bresp,
  output logic                         s_axi_bvalid,
  input  wire logic                    s_axi_bready,
  input  wire logic [15:0]             s_axi_araddr,
  input  wire logic                    s_axi_arvalid,
  output logic                         s_axi_arready,
  output logic [31:0]                  s_axi_rdata,
  output logic [1:0]                   s_axi_rresp,
  output logic                         s_axi_rvalid,
  input  wire logic                    s_axi_rready,
  input  wire aqdb_pkg::queue_create_s createReq,
  output logic                         createReady,
  output aqdb_pkg::admin_queues_s      adminQueues,
  output aqdb_pkg::new_cmds_s          newCmds,
  output logic                         irq
);
  import aqdb_pkg::*;

  localparam int QID_W = $clog2(NUM_QUEUES);

  logic [DEPTH_W-1:0]    cqDepth;
  logic [DEPTH_W-1:0]    sqDepth;
  logic [BASE_W-1:0]     sqBase;
  logic [BASE_W-1:0]     cqBase;
  logic [SET_W-1:0]      strideSet;
  logic [SET_W-1:0]      pageSet;
  logic [ARB_W-1:0]      arbSet;
  logic [NUM_EVENTS-1:0] irqStatus;
  logic [NUM_EVENTS-1:0] irqMask;
  logic [NUM_EVENTS-1:0] events;
  logic [NUM_QUEUES-1:0] created;
  logic [TAIL_W-1:0]     adminTail;
  logic                  awHeld;
  logic                  wHeld;
  logic [15:0]           awAddr;
  logic [31:0]           wData;
  logic [3:0]            wStrb;
  logic                  doWrite;
  logic [15:0]           regAddr;
  logic [32:0]           wrOld;
  logic [31:0]           merged;
  logic [32:0]           rdHit;
  logic [15:0]           dbOff;
  logic [15:0]           dbSlot;
  logic [15:0]           strideMask;
  logic [15:0]           dbQidFull;
  logic [QID_W-1:0]      dbQid;
  logic                  isDbRegion;
  logic                  isSqDb;
  logic                  dbTake;
  logic                  dbKnown;
  logic [BASE_LO_W-1:0]  pageMask;
  db_state_e             state;
  logic                  pendAdmin;
  logic [15:0]           pendQid;
  logic [TAIL_W-1:0]     pendTail;
  queue_entry_s          memQ;
  queue_entry_s          memWrData;
  logic                  memWrEn;
  logic [QID_W-1:0]      memWrAddr;
  logic [TAIL_W-1:0]     oldTail;
  logic [15:0]           depthZ;
  logic                  tailOk;
  logic [16:0]           wrapSum;
  logic [15:0]           count;
  logic                  createTake;

  // ****************************************
  // Register read values
  // ****************************************
  function automatic logic [32:0] regValue(input logic [15:0] addr);
    logic [15:0] a;
    a = {addr[15:2], 2'b00};
    if (a == OFS_SIZES) begin
      regValue = {1'b1, 4'h0, cqDepth, 4'h0, sqDepth};
    end else if (a == OFS_SQ_LO) begin
      regValue = {1'b1, sqBase[BASE_LO_W-1:0], 12'h000};
    end else if (a == OFS_SQ_HI) begin
      regValue = {1'b1, sqBase[BASE_W-1:BASE_LO_W]};
    end else if (a == OFS_CQ_LO) begin
      regValue = {1'b1, cqBase[BASE_LO_W-1:0], 12'h000};
    end else if (a == OFS_CQ_HI) begin
      regValue = {1'b1, cqBase[BASE_W-1:BASE_LO_W]};
    end else if (a == OFS_CONFIG) begin
      regValue = {1'b1, 21'h000000, arbSet, pageSet, strideSet};
    end else if (a == OFS_IRQ_STAT) begin
      regValue = {1'b1, 27'h0000000, irqStatus};
    end else if (a == OFS_IRQ_MASK) begin
      regValue = {1'b1, 27'h0000000, irqMask};
    end else if (a >= OFS_DOORBELL) begin
      regValue = {1'b1, 32'h00000000};
    end else begin
      regValue = {1'b0, 32'h00000000};
    end
  endfunction

  function automatic logic [31:0] mergeLanes(input logic [31:0] old, input logic [31:0] data,
                                             input logic [3:0] strb);
    logic [31:0] mask;
    for (int i = 0; i < 4; i++) begin
      mask[i*8 +: 8] = {8{strb[i]}};
    end
    mergeLanes = (old & ~mask) | (data & mask);
  endfunction

  // ****************************************
  // AXI write channel
  // ****************************************
  assign s_axi_awready = !awHeld;
  assign s_axi_wready  = !wHeld;
  assign doWrite       = awHeld && wHeld && !s_axi_bvalid && (state == ST_IDLE);
  assign regAddr       = {awAddr[15:2], 2'b00};
  assign isDbRegion    = awAddr >= OFS_DOORBELL;

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      awHeld <= 1'b0;
      awAddr <= '0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      awHeld <= 1'b1;
      awAddr <= s_axi_awaddr;
    end else if (doWrite) begin
      awHeld <= 1'b0;
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      wHeld <= 1'b0;
      wData <= '0;
      wStrb <= '0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      wHeld <= 1'b1;
      wData <= s_axi_wdata;
      wStrb <= s_axi_wstrb;
    end else if (doWrite) begin
      wHeld <= 1'b0;
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end else if (doWrite) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wrOld[32] ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  always_comb begin
    wrOld    = regValue(awAddr);
    rdHit    = regValue(s_axi_araddr);
    merged   = mergeLanes(wrOld[31:0], wData, wStrb);
    pageMask = BASE_LO_W'((20'h00001 << pageSet) - 20'h00001);
  end

  // ****************************************
  // Admin queue registers
  // ****************************************
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      cqDepth <= '0;
      sqDepth <= '0;
    end else if (doWrite && regAddr == OFS_SIZES) begin
      cqDepth <= merged[CQ_DEPTH_LSB +: DEPTH_W];
      sqDepth <= merged[SQ_DEPTH_LSB +: DEPTH_W];
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      sqBase <= '0;
      cqBase <= '0;
    end else if (doWrite) begin
      if (regAddr == OFS_SQ_LO) begin
        sqBase[BASE_LO_W-1:0] <= merged[31:BASE_LSB];
      end else if (regAddr == OFS_SQ_HI) begin
        sqBase[BASE_W-1:BASE_LO_W] <= merged;
      end else if (regAddr == OFS_CQ_LO) begin
        cqBase[BASE_LO_W-1:0] <= merged[31:BASE_LSB];
      end else if (regAddr == OFS_CQ_HI) begin
        cqBase[BASE_W-1:BASE_LO_W] <= merged;
      end
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      strideSet <= '0;
      pageSet   <= '0;
      arbSet    <= '0;
      irqMask   <= '0;
    end else if (doWrite && regAddr == OFS_CONFIG) begin
      strideSet <= merged[STRIDE_LSB +: SET_W];
      pageSet   <= merged[MPS_LSB +: SET_W];
      arbSet    <= merged[ARB_LSB +: ARB_W];
    end else if (doWrite && regAddr == OFS_IRQ_MASK) begin
      irqMask <= merged[NUM_EVENTS-1:0];
    end
  end

  // the admin fetch and post addresses are only these two bases
  assign adminQueues = '{qid:      ADMIN_QID,
                         cqVector: ADMIN_VECTOR,
                         arbSel:   arbSet,
                         pageSize: pageSet,
                         sqDepth:  sqDepth,
                         cqDepth:  cqDepth,
                         sqBase:   {sqBase, 12'h000},
                         cqBase:   {cqBase, 12'h000}};

  // ****************************************
  // Doorbell decode
  // ****************************************
  always_comb begin
    dbOff      = awAddr - OFS_DOORBELL;
    strideMask = (16'h0004 << strideSet) - 16'h0001;
    dbSlot     = dbOff >> (DB_SHIFT + int'(strideSet));
    dbQidFull  = {1'b0, dbSlot[15:1]};
    dbQid      = dbQidFull[QID_W-1:0];
    isSqDb     = isDbRegion && ((dbOff & strideMask) == 16'h0000) && !dbSlot[0];
    dbTake     = doWrite && isSqDb && (wStrb[1:0] == 2'b11);
    dbKnown    = (dbQidFull == ADMIN_QID) ||
                 ((dbQidFull < 16'(NUM_QUEUES)) && created[dbQid]);
  end

  // ****************************************
  // Tail update and new command count
  // ****************************************
  always_comb begin
    oldTail = pendAdmin ? adminTail : memQ.tail;
    depthZ  = pendAdmin ? 16'(sqDepth) : memQ.depth;
    tailOk  = pendTail <= depthZ;
    wrapSum = 17'(pendTail) + 17'(depthZ) + 17'h00001 - 17'(oldTail);
    count   = (pendTail >= oldTail) ? (pendTail - oldTail) : wrapSum[15:0];
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      state     <= ST_IDLE;
      pendAdmin <= 1'b0;
      pendQid   <= '0;
      pendTail  <= '0;
    end else begin
      case (state)
        ST_IDLE: begin
          if (dbTake && dbKnown) begin
            state     <= ST_UPDATE;
            pendAdmin <= dbQidFull == ADMIN_QID;
            pendQid   <= dbQidFull;
            pendTail  <= wData[TAIL_W-1:0];
          end
        end
        ST_UPDATE: begin
          state <= ST_IDLE;
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      adminTail <= '0;
    end else if (state == ST_UPDATE && tailOk && pendAdmin) begin
      adminTail <= pendTail;
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      newCmds <= '0;
    end else begin
      newCmds.valid <= (state == ST_UPDATE) && tailOk;
      if (state == ST_UPDATE) begin
        newCmds.qid   <= pendQid;
        newCmds.count <= count;
        newCmds.tail  <= pendTail;
      end
    end
  end

  // ****************************************
  // I/O queue creation and tail store
  // ****************************************
  assign createReady = state != ST_UPDATE;
  assign createTake  = createReq.valid && createReady && (createReq.qid != ADMIN_QID) &&
                       (createReq.qid < 16'(NUM_QUEUES));

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      created <= '0;
    end else if (createTake) begin
      created[createReq.qid[QID_W-1:0]] <= 1'b1;
    end
  end

  always_comb begin
    memWrEn   = createTake;
    memWrAddr = createReq.qid[QID_W-1:0];
    memWrData = '{depth: createReq.depth, tail: 16'h0000};
    if (state == ST_UPDATE) begin
      memWrEn   = tailOk && !pendAdmin;
      memWrAddr = pendQid[QID_W-1:0];
      memWrData = '{depth: memQ.depth, tail: pendTail};
    end
  end

  tail_store #(
    .WIDTH ($bits(queue_entry_s)),
    .DEPTH (NUM_QUEUES)
  ) tailStore (
    .core_clk (core_clk),
    .sys_rst  (sys_rst),
    .wrEn     (memWrEn),
    .wrAddr   (memWrAddr),
    .wrData   (memWrData),
    .rdEn     (doWrite),
    .rdAddr   (dbQid),
    .rdData   (memQ)
  );

  // ****************************************
  // Interrupt status and mask
  // ****************************************
  always_comb begin
    events              = '0;
    events[EV_ADMIN_DB] = (state == ST_UPDATE) && tailOk && pendAdmin;
    events[EV_IO_DB]    = (state == ST_UPDATE) && tailOk && !pendAdmin;
    events[EV_BAD_DB]   = (dbTake && !dbKnown) || ((state == ST_UPDATE) && !tailOk);
    events[EV_MISALIGN] = doWrite && ((regAddr == OFS_SQ_LO) || (regAddr == OFS_CQ_LO)) &&
                          ((merged[31:BASE_LSB] & pageMask) != '0);
    events[EV_BAD_SIZE] = doWrite && (regAddr == OFS_SIZES) &&
                          ((merged[CQ_DEPTH_LSB +: DEPTH_W] == '0) ||
                           (merged[SQ_DEPTH_LSB +: DEPTH_W] == '0));
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      irqStatus <= '0;
    end else if (doWrite && regAddr == OFS_IRQ_STAT) begin
      irqStatus <= (irqStatus & ~NUM_EVENTS'(mergeLanes(32'h00000000, wData, wStrb))) | events;
    end else begin
      irqStatus <= irqStatus | events;
    end
  end

  assign irq = |(irqStatus & irqMask);

  // ****************************************
  // AXI read channel
  // ****************************************
  assign s_axi_arready = !s_axi_rvalid;

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= '0;
      s_axi_rresp  <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rdHit[31:0];
      s_axi_rresp  <= rdHit[32] ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule

// *** verif/aqdb_monitor.sv ***
// Concurrent checks on the admin queue and doorbell register block.
// Bound to the block's top module; sees only its ports.
`timescale 1ns/1ps
module aqdb_monitor (
  input wire logic                    core_clk,
  input wire logic                    sys_rst,
  input wire logic                    s_axi_bvalid,
  input wire logic                    s_axi_bready,
  input wire logic                    s_axi_rvalid,
  input wire logic                    s_axi_rready,
  input wire logic                    s_axi_arready,
  input wire logic                    createReady,
  input wire aqdb_pkg::admin_queues_s adminQueues,
  input wire aqdb_pkg::new_cmds_s     newCmds,
  input wire logic                    irq
);
  import aqdb_pkg::*;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  a_admin_qid: assert property (adminQueues.qid == ADMIN_QID) else $error("admin qid not zero");
  a_cq_vector: assert property (adminQueues.cqVector == ADMIN_VECTOR) else $error("vector not zero");
  a_base_reserved: assert property (adminQueues.sqBase[11:0] == 12'h000 && adminQueues.cqBase[11:0] == 12'h000)
    else $error("base low bits set");
  a_pulse_single: assert property (newCmds.valid |=> !newCmds.valid) else $error("newCmds pulse too long");
  a_update_busy: assert property (newCmds.valid |-> !$past(createReady)) else $error("no update cycle");
  a_admin_wrap: assert property (newCmds.valid && newCmds.qid == 16'h0000 |->
    newCmds.count <= adminQueues.sqDepth && newCmds.tail <= adminQueues.sqDepth) else $error("admin count out of range");
  a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid) else $error("bvalid dropped");
  a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid) else $error("rvalid dropped");
  a_ar_blocked: assert property (s_axi_rvalid |-> !s_axi_arready) else $error("arready while rvalid");
  c_new_cmds: cover property (newCmds.valid);
  c_wrap: cover property (newCmds.valid && newCmds.count > newCmds.tail);
  c_irq: cover property ($rose(irq));
endmodule

bind admin_queue_doorbell_regs aqdb_monitor i_aqdb_monitor (.core_clk, .sys_rst, .s_axi_bvalid, .s_axi_bready,
  .s_axi_rvalid, .s_axi_rready, .s_axi_arready, .createReady, .adminQueues, .newCmds, .irq);

// *** verif/axi_lite_host.sv ***
// Host software model: an AXI4-Lite master with one write and one read task.
// Assumes a clock from the bench; released address and data lines show inverted values, while the strobes stay at all ones.
`timescale 1ns/1ps
module axi_lite_host (
  input  wire logic        core_clk,
  output logic      [15:0] s_axi_awaddr,
  output logic             s_axi_awvalid,
  input  wire logic        s_axi_awready,
  output logic      [31:0] s_axi_wdata,
  output logic      [3:0]  s_axi_wstrb,
  output logic             s_axi_wvalid,
  input  wire logic        s_axi_wready,
  input  wire logic        s_axi_bvalid,
  output logic             s_axi_bready,
  output logic      [15:0] s_axi_araddr,
  output logic             s_axi_arvalid,
  input  wire logic        s_axi_arready,
  input  wire logic        s_axi_rvalid,
  output logic             s_axi_rready
);
  initial {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wstrb, s_axi_wvalid, s_axi_bready,
           s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
  task automatic write(input logic [15:0] a, input logic [31:0] d);
    int n;
    n = 0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= 4'hf;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge core_clk);
      if (s_axi_awready) begin
        s_axi_awvalid <= 1'b0;
        s_axi_awaddr <= ~a;
      end
      if (s_axi_wready) begin
        s_axi_wvalid <= 1'b0;
        s_axi_wdata <= ~d;
      end
      if (s_axi_bvalid) s_axi_bready <= 1'b0;
    end while (++n < 100 && |{s_axi_awvalid, s_axi_wvalid, s_axi_bready});
    if (n >= 100) tb_top.mismatches++;
  endtask
  task automatic read(input logic [15:0] a); // Never aimed at the doorbell region
    int n;
    n = 0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge core_clk);
      if (s_axi_arready) begin
        s_axi_arvalid <= 1'b0;
        s_axi_araddr <= ~a;
      end
      if (s_axi_rvalid) s_axi_rready <= 1'b0;
    end while (++n < 100 && |{s_axi_arvalid, s_axi_rready});
    if (n >= 100) tb_top.mismatches++;
  endtask
endmodule

// *** verif/tb_top.sv ***
// Self-checking bench for the admin queue and doorbell register block.
// Expected results are queued by the driver and popped by an output watcher.
`timescale 1ns/1ps
module tb_top;
  import aqdb_pkg::*;
  logic          core_clk, sys_rst, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic          s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic          createReady, irq;
  logic [15:0]   s_axi_awaddr, s_axi_araddr;
  logic [31:0]   s_axi_wdata, s_axi_rdata;
  logic [3:0]    s_axi_wstrb;
  logic [1:0]    s_axi_bresp, s_axi_rresp;
  queue_create_s createReq;
  admin_queues_s adminQueues;
  new_cmds_s     newCmds;
  int            mismatches, checks, seed, t;
  logic [1:0]    bq[$];
  logic [33:0]   rq[$];
  logic [47:0]   nq[$];

  admin_queue_doorbell_regs #(.NUM_QUEUES(16)) i_admin_queue_doorbell_regs (.core_clk, .sys_rst, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .createReq, .createReady, .adminQueues, .newCmds, .irq);
  axi_lite_host i_axi_lite_host (.core_clk, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rvalid, .s_axi_rready);

  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end
  task automatic conclude;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic cmp(input string nm, input logic [63:0] e, input logic [63:0] g);
    checks++;
    if (e !== g) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [15:0] a, input logic [31:0] d, input logic [1:0] r = RESP_OKAY);
    bq.push_back(r);
    i_axi_lite_host.write(a, d);
  endtask
  task automatic rd(input logic [15:0] a, input logic [31:0] d, input logic [1:0] r = RESP_OKAY);
    rq.push_back({r, d});
    i_axi_lite_host.read(a);
  endtask
  always @(posedge core_clk) begin
    if ((s_axi_bvalid & s_axi_bready) === 1'b1) cmp("bresp", bq.pop_front(), s_axi_bresp);
    if ((s_axi_rvalid & s_axi_rready) === 1'b1) cmp("rdata", rq.pop_front(), {s_axi_rresp, s_axi_rdata});
    if (newCmds.valid === 1'b1) cmp("newCmds", nq.pop_front(), {newCmds.qid, newCmds.count, newCmds.tail});
  end
  initial begin
    repeat (20000) @(posedge core_clk);
    mismatches++;
    conclude();
  end
  initial begin
    seed = 32'h44c44197;
    createReq = '0;
    sys_rst = 1'b1;
    repeat (4) @(posedge core_clk);
    sys_rst <= 1'b0;
    @(posedge core_clk);
    rd(OFS_SIZES, 32'h0);
    rd(16'h0100, 32'h0, RESP_SLVERR);
    wr(16'h0100, 32'h1, RESP_SLVERR);
    wr(OFS_SIZES, 32'hffffffff);
    rd(OFS_SIZES, 32'h0fff0fff);
    cmp("depths", 24'hffffff, {adminQueues.cqDepth, adminQueues.sqDepth});
    $display("test sizes done");
    wr(OFS_SQ_LO, 32'h12345fff);
    wr(OFS_SQ_HI, 32'h89abcdef);
    wr(OFS_CQ_LO, 32'hfedcb001);
    wr(OFS_CQ_HI, 32'h00000042);
    rd(OFS_SQ_LO, 32'h12345000);
    rd(OFS_CQ_LO, 32'hfedcb000);
    cmp("sqBase", 64'h89abcdef12345000, adminQueues.sqBase);
    cmp("cqBase", 64'h00000042fedcb000, adminQueues.cqBase);
    $display("test bases done");
    wr(OFS_CONFIG, 32'h00000501);
    cmp("arbSel", 3'h5, adminQueues.arbSel);
    wr(OFS_SIZES, 32'h00070007);
    nq.push_back({16'h0000, 16'h0005, 16'h0005});
    wr(OFS_DOORBELL, 32'hffff0005);
    nq.push_back({16'h0000, 16'h0005, 16'h0002});
    wr(OFS_DOORBELL, 32'h00000002);
    repeat (3) @(posedge core_clk);
    cmp("irq", 1'b0, irq);
    wr(OFS_IRQ_MASK, 32'h00000001);
    cmp("irq", 1'b1, irq);
    $display("test admin doorbell done");
    createReq <= '{1'b1, 16'h0003, 16'h000f};
    t = 0;
    do @(posedge core_clk); while (createReady !== 1'b1 && ++t < 50);
    if (t >= 50) mismatches++;
    createReq.valid <= 1'b0;
    nq.push_back({16'h0003, 16'h0009, 16'h0009});
    wr(16'h1030, 32'h00000009);
    wr(16'h1008, 32'h00000004);
    wr(16'h1038, 32'h00000005);
    t = $random(seed) & 15;
    if (t == 9) t = 10;
    nq.push_back({16'h0003, 16'((t + 7) % 16), 16'(t)});
    wr(16'h1030, 32'(t));
    $display("test io doorbell done");
    repeat (3) @(posedge core_clk);
    wr(OFS_IRQ_STAT, 32'h0000001f);
    wr(OFS_IRQ_MASK, 32'h00000004);
    cmp("irq", 1'b0, irq);
    wr(16'h1030, 32'h00000014);
    repeat (4) @(posedge core_clk);
    cmp("irq", 1'b1, irq);
    rd(OFS_IRQ_STAT, 32'h00000004);
    wr(OFS_IRQ_STAT, 32'h00000004);
    repeat (2) @(posedge core_clk);
    cmp("irq", 1'b0, irq);
    wr(OFS_CONFIG, 32'h00000511);
    cmp("pageSize", 4'h1, adminQueues.pageSize);
    wr(OFS_SQ_LO, 32'h00001000);
    wr(OFS_CQ_LO, 32'h00002000);
    wr(OFS_SIZES, 32'h00000007);
    rd(OFS_CQ_LO, 32'h00002000);
    rd(OFS_IRQ_STAT, 32'h00000018);
    $display("test interrupt done");
    repeat (5) @(posedge core_clk);
    cmp("pending", 0, bq.size() + rq.size() + nq.size());
    conclude();
  end
endmodule
